/* pmr_regs.sv */
// Notes on behaviour
// - Keep-on bit holds linear regulator past release
// - Discharge output while regulator disabled, if enabled
// - Low six bits select regulator voltage code
// - Code maps to 25/50/100 mV step table
// - Bit 7 at 09h forces fixed-frequency mode
// - Bits 6,5 at 09h show power-bad or disabled
// - Hold bit ORed with button enables converter; regulator also needs hold pin, button or keep-on bit
// - Bit 4 at 0Ah shows debounced button
// - Pin data reads input; write 0 drives low
// - Direction bits: 1 input, 0 output
// - Bits 7,6 select LED driver on pins 3,2
// - Mask bit 1 suppresses event; resets to 1
// - Charger flags set on listed edges
// - Flags set when unmasked, cleared by read
// - Comparator flag suppressed while comparator disabled
// - Undervoltage or reset reloads all defaults
`include "pmr_consts.svh"

module pmr_regs import pmr_pkg::*; #(
	parameter int DEBOUNCE_CYC = `PMR_DEBOUNCE_CYC,
	parameter logic [6:0] DEV_ADDR = `PMR_DEV_ADDR
) (
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire logic undervoltage_i,
	input wire logic scl_i,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe_n_o,
	input wire logic button_input_n_i,
	input wire logic linreg_hold_pin_i,
	input wire logic converter_power_bad_i,
	input wire logic linreg_power_bad_i,
	input wire logic [7:0] charger_status_i,
	input wire logic vbat_comp_en_i,
	input wire logic [3:0] pin_i,
	output logic [3:0] pin_o,
	output logic [3:0] pin_oe_n_o,
	output logic [1:0] led_drive_o,
	output logic linreg_enable_o,
	output logic linreg_discharge_o,
	output logic [5:0] linreg_vcode_o,
	output logic [11:0] linreg_mv_o,
	output logic converter_enable_o,
	output logic converter_forced_pwm_o,
	output logic reset_delay_long_o
);
	localparam int DBW = $clog2(DEBOUNCE_CYC + 1);
	localparam int SW = 17;
	// Button pin idles high (released); avoids a false press after reset
	localparam logic [SW-1:0] SYNC_RST = 17'h08000;

	logic [SW-1:0] raw, s1_q, s2_q, s3_q, f_q;
	logic uvlo, btn_n, hold_pin, conv_bad, lin_bad;
	logic [7:0] chg;
	logic [3:0] pins;
	logic clr;

	logic [7:0] addr;
	logic wr_en, rd_load, rd_done;
	logic [7:0] wr_data, rd_data;

	logic [7:0] linreg_q;
	logic fpwm_q, hold_q, rdly_q;
	logic [3:0] pdata_q, pdir_q;
	logic [1:0] led_q;
	logic [7:0] mask0_q, mask1_q;
	logic [6:0] mask2_q;
	logic [7:0] flags_q, snap_q, chg_prev_q, flag_set;
	logic btn_q;
	logic [DBW-1:0] db_cnt_q;
	logic sys_hold, lin_en, conv_en;

	assign raw = {undervoltage_i, button_input_n_i, linreg_hold_pin_i,
		converter_power_bad_i, linreg_power_bad_i, charger_status_i, pin_i};

	// Three-stage sync, change taken once stages two and three agree
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			s1_q <= SYNC_RST;
			s2_q <= SYNC_RST;
			s3_q <= SYNC_RST;
			f_q <= SYNC_RST;
		end else begin
			s1_q <= raw;
			s2_q <= s1_q;
			s3_q <= s2_q;
			f_q <= (~(s2_q ^ s3_q) & s3_q) | ((s2_q ^ s3_q) & f_q);
		end
	end

	assign uvlo = f_q[16];
	assign btn_n = f_q[15];
	assign hold_pin = f_q[14];
	assign conv_bad = f_q[13];
	assign lin_bad = f_q[12];
	assign chg = f_q[11:4];
	assign pins = f_q[3:0];
	assign clr = !rstn_i || uvlo;

	pmr_twi_slave #(
		.DEV_ADDR(DEV_ADDR)
	) u_twi (
		.clk_i(clk_i),
		.rstn_i(rstn_i),
		.scl_i(scl_i),
		.sda_i(sda_i),
		.sda_o(sda_o),
		.sda_oe_n_o(sda_oe_n_o),
		.addr_o(addr),
		.wr_en_o(wr_en),
		.wr_data_o(wr_data),
		.rd_data_i(rd_data),
		.rd_load_o(rd_load),
		.rd_done_o(rd_done)
	);

	// Button debounce: level must hold for the full count
	always_ff @(posedge clk_i) begin
		if (clr) begin
			btn_q <= 1'b0;
			db_cnt_q <= '0;
		end else if (btn_q == !btn_n) begin
			db_cnt_q <= '0;
		end else if (db_cnt_q == DBW'(DEBOUNCE_CYC - 1)) begin
			btn_q <= !btn_n;
			db_cnt_q <= '0;
		end else begin
			db_cnt_q <= db_cnt_q + DBW'(1);
		end
	end

	// Register writes; only writable fields are stored
	always_ff @(posedge clk_i) begin
		if (clr) begin
			linreg_q <= `PMR_RST_LINREG;
			fpwm_q <= `PMR_RST_FPWM;
			hold_q <= `PMR_RST_HOLD;
			rdly_q <= `PMR_RST_RDLY;
			pdata_q <= `PMR_RST_PINDATA;
			pdir_q <= `PMR_RST_PINDIR;
			led_q <= `PMR_RST_LED;
			mask0_q <= `PMR_RST_MASK;
			mask1_q <= `PMR_RST_MASK;
			mask2_q <= `PMR_RST_MASK2;
		end else if (wr_en) begin
			unique case (addr)
				`PMR_ADDR_LINREG: linreg_q <= wr_data;
				`PMR_ADDR_CTL0: fpwm_q <= wr_data[`PMR_CTL0_FPWM_BIT];
				`PMR_ADDR_CTL1: begin
					hold_q <= wr_data[`PMR_CTL1_HOLD_BIT];
					rdly_q <= wr_data[`PMR_CTL1_RDLY_BIT];
				end
				`PMR_ADDR_PINDATA: pdata_q <= wr_data[3:0];
				`PMR_ADDR_PINDIR: begin
					pdir_q <= wr_data[3:0];
					led_q <= {wr_data[`PMR_DIR_LED3_BIT], wr_data[`PMR_DIR_LED2_BIT]};
				end
				`PMR_ADDR_MASK0: mask0_q <= wr_data;
				`PMR_ADDR_MASK1: mask1_q <= wr_data;
				`PMR_ADDR_MASK2: mask2_q <= wr_data[7:1];
				default: ;
			endcase
		end
	end

	// Read mux; unmapped offsets read zero
	always_comb begin
		rd_data = 8'h00;
		unique case (addr)
			`PMR_ADDR_LINREG: rd_data = linreg_q;
			`PMR_ADDR_CTL0: rd_data = {fpwm_q, conv_bad || !conv_en,
				lin_bad || !lin_en, 5'h00};
			`PMR_ADDR_CTL1: rd_data = `PMR_CTL1_FIXED | {2'h0, hold_q, btn_q,
				3'h0, rdly_q};
			`PMR_ADDR_PINDATA: rd_data = {4'h0, pins};
			`PMR_ADDR_PINDIR: rd_data = `PMR_PINDIR_FIXED | {led_q, 2'h0, pdir_q};
			`PMR_ADDR_MASK0: rd_data = mask0_q;
			`PMR_ADDR_MASK1: rd_data = mask1_q;
			`PMR_ADDR_MASK2: rd_data = `PMR_MASK2_FIXED | {mask2_q, 1'b0};
			`PMR_ADDR_FLAGS: rd_data = flags_q;
			default: rd_data = 8'h00;
		endcase
	end

	// Event edges: rising for most, both edges for active and input-good
	always_comb begin
		flag_set = ((chg & ~chg_prev_q) | (`PMR_BOTH_EDGE & (chg ^ chg_prev_q)))
			& ~mask0_q;
		if (!vbat_comp_en_i) begin
			flag_set[`PMR_FLAG_VBAT_BIT] = 1'b0;
		end
	end

	// Read-clear drops only bits that were shifted out; new sets win
	always_ff @(posedge clk_i) begin
		if (clr) begin
			flags_q <= `PMR_RST_FLAGS;
			snap_q <= 8'h00;
			chg_prev_q <= 8'h00;
		end else begin
			chg_prev_q <= chg;
			if (rd_load) begin
				snap_q <= (addr == `PMR_ADDR_FLAGS) ? flags_q : 8'h00;
			end
			if (rd_done) begin
				flags_q <= (flags_q & ~snap_q) | flag_set;
			end else begin
				flags_q <= flags_q | flag_set;
			end
		end
	end

	// Enable logic
	assign sys_hold = hold_q || btn_q;
	assign conv_en = sys_hold;
	assign lin_en = sys_hold && (hold_pin || btn_q || linreg_q[`PMR_LINREG_KEEP_BIT]);

	function automatic logic [11:0] code_to_mv(input logic [5:0] c);
		if (c <= `PMR_CODE_FINE_END) begin
			code_to_mv = `PMR_MV_BASE + 12'(c) * `PMR_MV_STEP_FINE;
		end else if (c <= `PMR_CODE_COARSE_END) begin
			code_to_mv = `PMR_MV_MID + 12'(c - `PMR_CODE_FINE_END) * `PMR_MV_STEP_COARSE;
		end else begin
			code_to_mv = `PMR_MV_TOP + 12'(c - `PMR_CODE_COARSE_END - 6'h1) * `PMR_MV_STEP_TOP;
		end
	endfunction

	// Regulator outputs
	always_ff @(posedge clk_i) begin
		if (clr) begin
			linreg_enable_o <= 1'b0;
			linreg_discharge_o <= 1'b0;
			linreg_vcode_o <= 6'(`PMR_RST_LINREG & 8'h3F);
			linreg_mv_o <= 12'h000;
			converter_enable_o <= 1'b0;
			converter_forced_pwm_o <= `PMR_RST_FPWM;
			reset_delay_long_o <= `PMR_RST_RDLY;
		end else begin
			linreg_enable_o <= lin_en;
			linreg_discharge_o <= linreg_q[`PMR_LINREG_DISCH_BIT] && !lin_en;
			linreg_vcode_o <= linreg_q[5:0];
			linreg_mv_o <= code_to_mv(linreg_q[5:0]);
			converter_enable_o <= conv_en;
			converter_forced_pwm_o <= fpwm_q;
			reset_delay_long_o <= rdly_q;
		end
	end

	// Open-drain pins: drive low when output and data 0
	always_ff @(posedge clk_i) begin
		if (clr) begin
			pin_o <= 4'h0;
			pin_oe_n_o <= 4'hF;
			led_drive_o <= 2'h0;
		end else begin
			pin_o <= 4'h0;
			pin_oe_n_o <= pdir_q | pdata_q;
			led_drive_o <= led_q & ~pdir_q[3:2] & ~pdata_q[3:2];
		end
	end
endmodule

/* pmr_consts.svh */
`ifndef PMR_CONSTS_SVH
`define PMR_CONSTS_SVH

// Register offsets
`define PMR_ADDR_LINREG 8'h08
`define PMR_ADDR_CTL0 8'h09
`define PMR_ADDR_CTL1 8'h0A
`define PMR_ADDR_PINDATA 8'h0B
`define PMR_ADDR_PINDIR 8'h0C
`define PMR_ADDR_MASK0 8'h0D
`define PMR_ADDR_MASK1 8'h0E
`define PMR_ADDR_MASK2 8'h0F
`define PMR_ADDR_FLAGS 8'h10

// Field positions
`define PMR_LINREG_KEEP_BIT 7
`define PMR_LINREG_DISCH_BIT 6
`define PMR_CTL0_FPWM_BIT 7
`define PMR_CTL1_HOLD_BIT 5
`define PMR_CTL1_RDLY_BIT 0
`define PMR_DIR_LED3_BIT 7
`define PMR_DIR_LED2_BIT 6
`define PMR_FLAG_VBAT_BIT 1

// Reset values, fixed read bits and both-edge event mask
`define PMR_RST_LINREG 8'h65
`define PMR_RST_FPWM 1'b0
`define PMR_RST_HOLD 1'b0
`define PMR_RST_RDLY 1'b1
`define PMR_RST_PINDATA 4'hF
`define PMR_RST_PINDIR 4'h3
`define PMR_RST_LED 2'h3
`define PMR_RST_MASK 8'hFF
`define PMR_RST_MASK2 7'h7F
`define PMR_RST_FLAGS 8'h00
`define PMR_CTL1_FIXED 8'h04
`define PMR_PINDIR_FIXED 8'h30
`define PMR_MASK2_FIXED 8'h01
`define PMR_BOTH_EDGE 8'h0C

// Voltage code table, millivolts
`define PMR_MV_BASE 12'h320
`define PMR_MV_STEP_FINE 12'h019
`define PMR_MV_MID 12'h640
`define PMR_MV_STEP_COARSE 12'h032
`define PMR_MV_TOP 12'hC1C
`define PMR_MV_STEP_TOP 12'h064
`define PMR_CODE_FINE_END 6'h20
`define PMR_CODE_COARSE_END 6'h3C

// Timing and device address
`define PMR_CLK_HZ 20000000
`define PMR_DEBOUNCE_US 1000
`define PMR_DEBOUNCE_CYC (`PMR_DEBOUNCE_US * (`PMR_CLK_HZ / 1000000))
`define PMR_DEV_ADDR 7'h48

`endif

/* pmr_pkg.sv */
package pmr_pkg;
	typedef enum logic [2:0] {
		TS_IDLE,
		TS_ADDR,
		TS_REG,
		TS_WDATA,
		TS_RDATA,
		TS_RACK
	} pmr_twi_state_t;
endpackage

/* pmr_twi_slave.sv */
`include "pmr_consts.svh"

module pmr_twi_slave import pmr_pkg::*; #(
	parameter logic [6:0] DEV_ADDR = `PMR_DEV_ADDR
) (
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire logic scl_i,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe_n_o,
	output logic [7:0] addr_o,
	output logic wr_en_o,
	output logic [7:0] wr_data_o,
	input wire logic [7:0] rd_data_i,
	output logic rd_load_o,
	output logic rd_done_o
);
	logic [1:0] s1_q, s2_q, s3_q, f_q, p_q;
	logic scl, sda, rise, fall, start, stop;
	pmr_twi_state_t st_q;
	logic [7:0] sh_q;
	logic [3:0] cnt_q;
	logic ack_q, rw_q;

	// Three-stage sync, change taken once stages two and three agree
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			s1_q <= 2'h3;
			s2_q <= 2'h3;
			s3_q <= 2'h3;
			f_q <= 2'h3;
			p_q <= 2'h3;
		end else begin
			s1_q <= {scl_i, sda_i};
			s2_q <= s1_q;
			s3_q <= s2_q;
			f_q <= (~(s2_q ^ s3_q) & s3_q) | ((s2_q ^ s3_q) & f_q);
			p_q <= f_q;
		end
	end

	assign scl = f_q[1];
	assign sda = f_q[0];
	assign rise = scl & ~p_q[1];
	assign fall = ~scl & p_q[1];
	assign start = scl & p_q[1] & p_q[0] & ~sda;
	assign stop = scl & p_q[1] & ~p_q[0] & sda;

	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			st_q <= TS_IDLE;
			sh_q <= 8'h00;
			cnt_q <= 4'h0;
			ack_q <= 1'b0;
			rw_q <= 1'b0;
			addr_o <= 8'h00;
			wr_en_o <= 1'b0;
			wr_data_o <= 8'h00;
			rd_load_o <= 1'b0;
			rd_done_o <= 1'b0;
			sda_o <= 1'b0;
			sda_oe_n_o <= 1'b1;
		end else begin
			wr_en_o <= 1'b0;
			rd_load_o <= 1'b0;
			rd_done_o <= 1'b0;
			if (start) begin
				st_q <= TS_ADDR;
				cnt_q <= 4'h0;
				ack_q <= 1'b0;
				sda_oe_n_o <= 1'b1;
			end else if (stop) begin
				st_q <= TS_IDLE;
				ack_q <= 1'b0;
				sda_oe_n_o <= 1'b1;
			end else if (rise) begin
				if (!ack_q && (st_q == TS_ADDR || st_q == TS_REG || st_q == TS_WDATA)) begin
					sh_q <= {sh_q[6:0], sda};
					cnt_q <= cnt_q + 4'h1;
				end else if (st_q == TS_RACK) begin
					// Byte fully sent: read-clear may act now
					rd_done_o <= 1'b1;
					if (sda) begin
						st_q <= TS_IDLE;
					end
				end
			end else if (fall) begin
				if (ack_q) begin
					ack_q <= 1'b0;
					sda_oe_n_o <= 1'b1;
					cnt_q <= 4'h0;
					if (st_q == TS_RDATA) begin
						sh_q <= rd_data_i;
						sda_oe_n_o <= rd_data_i[7];
						rd_load_o <= 1'b1;
					end
				end else if (st_q == TS_RACK) begin
					st_q <= TS_RDATA;
					cnt_q <= 4'h0;
					sh_q <= rd_data_i;
					sda_oe_n_o <= rd_data_i[7];
					rd_load_o <= 1'b1;
				end else if (st_q == TS_RDATA) begin
					if (cnt_q == 4'h7) begin
						sda_oe_n_o <= 1'b1;
						st_q <= TS_RACK;
					end else begin
						sh_q <= {sh_q[6:0], 1'b0};
						sda_oe_n_o <= sh_q[6];
						cnt_q <= cnt_q + 4'h1;
					end
				end else if (cnt_q == 4'h8) begin
					cnt_q <= 4'h0;
					unique case (st_q)
						TS_ADDR: begin
							if (sh_q[7:1] == DEV_ADDR) begin
								ack_q <= 1'b1;
								sda_oe_n_o <= 1'b0;
								rw_q <= sh_q[0];
								st_q <= sh_q[0] ? TS_RDATA : TS_REG;
							end else begin
								st_q <= TS_IDLE;
							end
						end
						TS_REG: begin
							addr_o <= sh_q;
							ack_q <= 1'b1;
							sda_oe_n_o <= 1'b0;
							st_q <= TS_WDATA;
						end
						TS_WDATA: begin
							wr_en_o <= 1'b1;
							wr_data_o <= sh_q;
							ack_q <= 1'b1;
							sda_oe_n_o <= 1'b0;
						end
						default: st_q <= TS_IDLE;
					endcase
				end
			end
		end
	end
endmodule

/* pmr_regs_chk.sv */
module pmr_regs_chk import pmr_pkg::*; #(
	parameter int DEBOUNCE_CYC = 4
) (
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire logic undervoltage_i,
	input wire logic sda_o,
	input wire logic sda_oe_n_o,
	input wire logic button_input_n_i,
	input wire logic [3:0] pin_o,
	input wire logic [3:0] pin_oe_n_o,
	input wire logic [1:0] led_drive_o,
	input wire logic linreg_enable_o,
	input wire logic linreg_discharge_o,
	input wire logic [5:0] linreg_vcode_o,
	input wire logic [11:0] linreg_mv_o,
	input wire logic converter_enable_o,
	input wire logic converter_forced_pwm_o,
	input wire logic reset_delay_long_o
);
	logic [15:0] press_q;
	logic [2:0] up_q;
	function automatic logic [11:0] mv_of(input logic [5:0] c);
		if (c <= 6'h20)
			return 12'h320 + 12'(c) * 12'h019;
		if (c <= 6'h3C)
			return 12'h640 + 12'(c - 6'h20) * 12'h032;
		return 12'hBB8 + 12'(c - 6'h3C) * 12'h064;
	endfunction
	// Cycles the button has been held down
	always_ff @(posedge clk_i) begin
		if (!rstn_i || button_input_n_i)
			press_q <= 16'h0000;
		else if (press_q != 16'hFFFF)
			press_q <= press_q + 16'h0001;
	end
	// Settling time after any reload
	always_ff @(posedge clk_i) begin
		if (!rstn_i || undervoltage_i)
			up_q <= 3'h0;
		else if (up_q != 3'h7)
			up_q <= up_q + 3'h1;
	end
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rstn_i);
	AST_RST_VALUES: assert property (disable iff (1'b0) !rstn_i |=>
		sda_oe_n_o && pin_oe_n_o == 4'hF && led_drive_o == 2'h0 && !linreg_enable_o
		&& linreg_vcode_o == 6'h25 && !converter_forced_pwm_o && reset_delay_long_o)
		else $error("reset values wrong");
	AST_UV_RELOAD: assert property (undervoltage_i [*8] |-> pin_oe_n_o == 4'hF
		&& !converter_forced_pwm_o && linreg_vcode_o == 6'h25) else $error("reload missed");
	AST_MV_TABLE: assert property (up_q == 3'h7 && $stable(linreg_vcode_o)
		|-> linreg_mv_o == mv_of(linreg_vcode_o)) else $error("voltage table wrong");
	AST_DISCH_OFF: assert property (linreg_discharge_o |-> !linreg_enable_o)
		else $error("discharge while on");
	AST_LIN_NEEDS_CONV: assert property (linreg_enable_o |-> converter_enable_o)
		else $error("regulator without converter");
	AST_BUTTON_ON: assert property (press_q > 16'(DEBOUNCE_CYC + 8)
		|-> converter_enable_o && linreg_enable_o) else $error("button does not enable");
	AST_LED_DRIVEN: assert property ((led_drive_o & pin_oe_n_o[3:2]) == 2'h0)
		else $error("led current on undriven pin");
	AST_PIN_LOW_ONLY: assert property (pin_o == 4'h0) else $error("pin driven high");
	AST_SDA_LOW_ONLY: assert property (sda_o == 1'b0) else $error("sda driven high");
endmodule

bind pmr_regs pmr_regs_chk #(.DEBOUNCE_CYC(DEBOUNCE_CYC)) pmr_regs_chk_i (.*);

/* pmr_host.sv */
module pmr_host #(
	parameter logic [6:0] DEV = 7'h48
) (
	input wire logic clk_i,
	input wire logic sda_i,
	output logic scl_o,
	output logic sda_low_o,
	output logic acks_o,
	output logic rd_valid_o,
	output logic [7:0] rd_byte_o
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		scl_o = 1'b1;
		sda_low_o = 1'b0;
		acks_o = 1'b1;
		rd_valid_o = 1'b0;
		rd_byte_o = 8'h00;
	end
	// SDA moves only while SCL is low, except for start and stop
	task automatic step(input logic l, input logic c, input int n);
		sda_low_o <= l;
		scl_o <= c;
		repeat (n) @(posedge clk_i);
	endtask
	task automatic put(input logic b);
		step(!b, 1'b0, 6);
		step(!b, 1'b1, 12);
		step(!b, 1'b0, 6);
	endtask
	task automatic get(output logic b);
		step(1'b0, 1'b0, 6);
		step(1'b0, 1'b1, 6);
		b = sda_i;
		step(1'b0, 1'b1, 6);
		step(1'b0, 1'b0, 6);
	endtask
	task automatic start();
		step(1'b0, scl_o, 6);
		step(1'b0, 1'b1, 6);
		step(1'b1, 1'b1, 6);
		step(1'b1, 1'b0, 6);
	endtask
	task automatic stop();
		step(1'b1, 1'b0, 6);
		step(1'b1, 1'b1, 6);
		step(1'b0, 1'b1, 12);
	endtask
	task automatic send(input logic [7:0] d);
		logic a;
		for (int i = 7; i >= 0; i--)
			put(d[i]);
		get(a);
		acks_o <= acks_o & !a;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		acks_o <= 1'b1;
		start();
		send({DEV, 1'b0});
		send(a);
		send(d);
		stop();
	endtask
	// One byte read, closed by a NACK
	task automatic rd(input logic [7:0] a);
		logic [7:0] d;
		acks_o <= 1'b1;
		start();
		send({DEV, 1'b0});
		send(a);
		start();
		send({DEV, 1'b1});
		for (int i = 7; i >= 0; i--)
			get(d[i]);
		put(1'b1);
		stop();
		rd_byte_o <= d;
		rd_valid_o <= 1'b1;
		@(posedge clk_i);
		rd_valid_o <= 1'b0;
	endtask
endmodule

/* pmr_regs_test.sv */
module pmr_regs_test;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [7:0] RA [11] = '{8'h08, 8'h09, 8'h0A, 8'h0B, 8'h0C, 8'h0D, 8'h0E,
		8'h0F, 8'h10, 8'h11, 8'h07};
	localparam logic [7:0] RE [11] = '{8'h65, 8'h60, 8'h05, 8'h05, 8'hF3, 8'hFF, 8'hFF,
		8'hFF, 8'h00, 8'h00, 8'h00};
	localparam logic [5:0] CODES [4] = '{6'h00, 6'h20, 6'h3C, 6'h3F};
	localparam logic [11:0] MV [4] = '{12'h320, 12'h640, 12'hBB8, 12'hCE4};
	logic clk_i = 1'b0;
	logic rstn_i = 1'b0;
	logic undervoltage_i = 1'b0;
	logic button_input_n_i = 1'b1;
	logic linreg_hold_pin_i = 1'b0;
	logic converter_power_bad_i = 1'b0;
	logic linreg_power_bad_i = 1'b0;
	logic vbat_comp_en_i = 1'b0;
	logic [7:0] charger_status_i = 8'h00;
	logic [3:0] ext = 4'h5;
	logic scl_i, sda_i, sda_o, sda_oe_n_o, sda_low, acks, rv;
	logic [7:0] rb;
	logic [3:0] pin_i, pin_o, pin_oe_n_o;
	logic [1:0] led_drive_o;
	logic linreg_enable_o, linreg_discharge_o, converter_enable_o, converter_forced_pwm_o;
	logic reset_delay_long_o;
	logic [5:0] linreg_vcode_o;
	logic [11:0] linreg_mv_o;
	int errors = 0;
	int tests_run = 0;
	logic [7:0] exp_q [$];
	// Open-drain wires with pull-ups
	assign sda_i = !sda_low && sda_oe_n_o;
	assign pin_i = ext & pin_oe_n_o;
	always #25 clk_i = !clk_i;
	pmr_regs #(.DEBOUNCE_CYC(4)) pmr_regs_i (.*);
	pmr_host pmr_host_i (.clk_i(clk_i), .sda_i(sda_i), .scl_o(scl_i), .sda_low_o(sda_low),
		.acks_o(acks), .rd_valid_o(rv), .rd_byte_o(rb));
	task automatic test_done();
		if (errors == 0 && tests_run > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [11:0] got, input logic [11:0] exp);
		tests_run++;
		if (got !== exp) begin
			errors++;
			$display("BAD %0t level %h want %h", $time, got, exp);
		end
	endtask
	task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp) begin
			errors++;
			$display("BAD %0t read %h want %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		pmr_host_i.wr(a, d);
		chk(12'(acks), 12'h001);
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		exp_q.push_back(e);
		pmr_host_i.rd(a);
		chk(12'(acks), 12'h001);
	endtask
	always @(posedge clk_i) begin
		if (rv === 1'b1)
			chk_byte(rb, exp_q.pop_front());
	end
	initial begin
		logic [7:0] r [5];
		logic [7:0] m, s1, e;
		logic pr, ce, le, cen;
		logic [3:0] oe;
		void'($urandom(32'h513F23EA));
		repeat (6) @(posedge clk_i);
		rstn_i <= 1'b1;
		repeat (6) @(posedge clk_i);
		foreach (RA[i])
			rd(RA[i], RE[i]);
		for (int k = 0; k < 4; k++) begin
			foreach (r[i])
				r[i] = 8'($urandom);
			r[0][5:0] = CODES[k];
			{button_input_n_i, linreg_hold_pin_i} <= 2'($urandom);
			{converter_power_bad_i, linreg_power_bad_i} <= 2'($urandom);
			ext <= 4'($urandom);
			for (int i = 0; i < 5; i++)
				wr(8'h08 + 8'(i), r[i]);
			repeat (20) @(posedge clk_i);
			pr = !button_input_n_i;
			ce = r[2][5] | pr;
			le = ce & (linreg_hold_pin_i | pr | r[0][7]);
			oe = r[4][3:0] | r[3][3:0];
			chk(12'({linreg_enable_o, linreg_discharge_o, converter_enable_o}),
				12'({le, !le & r[0][6], ce}));
			chk(12'({converter_forced_pwm_o, reset_delay_long_o}), 12'({r[1][7], r[2][0]}));
			chk(12'({pin_oe_n_o, led_drive_o}), 12'({oe, r[4][7:6] & ~oe[3:2]}));
			chk(12'(linreg_vcode_o), 12'(r[0][5:0]));
			chk(linreg_mv_o, MV[k]);
			rd(8'h08, r[0]);
			rd(8'h09, {r[1][7], converter_power_bad_i | !ce, linreg_power_bad_i | !le,
				5'h00});
			rd(8'h0A, {2'h0, r[2][5], pr, 3'h2, r[2][0]});
			rd(8'h0B, {4'h0, ext & oe});
			rd(8'h0C, {r[4][7:6], 2'h3, r[4][3:0]});
		end
		for (int k = 0; k < 4; k++) begin
			m = (k == 0) ? 8'h00 : 8'($urandom);
			cen = (k == 0) | 1'($urandom);
			s1 = 8'($urandom);
			vbat_comp_en_i <= cen;
			wr(8'h0D, m);
			rd(8'h0D, m);
			e = ~m & ((s1 & ~charger_status_i & 8'hF3) | ((s1 ^ charger_status_i) & 8'h0C));
			e[1] = e[1] & cen;
			charger_status_i <= s1;
			repeat (10) @(posedge clk_i);
			rd(8'h10, e);
			rd(8'h10, 8'h00);
		end
		button_input_n_i <= 1'b1;
		undervoltage_i <= 1'b1;
		repeat (10) @(posedge clk_i);
		undervoltage_i <= 1'b0;
		repeat (6) @(posedge clk_i);
		rd(8'h08, 8'h65);
		rd(8'h0C, 8'hF3);
		rd(8'h0D, 8'hFF);
		rstn_i <= 1'b0;
		repeat (6) @(posedge clk_i);
		rstn_i <= 1'b1;
		repeat (6) @(posedge clk_i);
		chk(12'(linreg_vcode_o), 12'h025);
		rd(8'h0A, 8'h05);
		test_done();
	end
	initial begin
		repeat (95000) @(posedge clk_i);
		errors++;
		test_done();
	end
endmodule
